// File: core/loop_cmd_regs.vh
// Constants for the loop command-mode control block
// Notes on behaviour
// - Listener code 0 stores up to 14 following data bytes into control registers 0..13.
// - Listener code 2 stores up to 12 following data bytes into character registers 0..11.
// - Register update lasts until the group is full or device is next made listener.
// - Listener code 3 empties transmit buffer and holds transmit line low until break-off.
// - Listener code 4 empties transmit buffer and ends break, resuming normal transmission.
// - After talker code 0, next send-data request outputs the 14 control registers.
// - After talker code 2, next send-data request outputs the 12 character registers.
// - Register readout stays selected until end-of-transmission, after last or not-ready.
// - In local mode received data bytes pass to the serial side unchanged.
// - In remote mode data bytes are instructions and are not forwarded.
// - Power-up and reset key put the device into local mode.
// - Remote enable only arms remote mode; local mode holds until made listener.
// - Remote enable then own listen address puts device in remote mode as listener.
// - Go-to-local acts only as listener; remote enable stays armed.
// - Not-remote-enable forces local mode and disarms remote enable.
// - Not-remote-enable is obeyed whether talker, listener or idle.
// - Remote mode persists across talker, listener or idle changes.
`ifndef LOOP_CMD_REGS_VH
`define LOOP_CMD_REGS_VH

`define CTRL_REG_COUNT   5'd14
`define CHAR_REG_COUNT   5'd12
`define CTRL_LAST_IDX    4'hd
`define CHAR_LAST_IDX    4'hb

`define LSN_SET_CTRL     5'h00
`define LSN_CLR_TX       5'h01
`define LSN_SET_CHAR     5'h02
`define LSN_BRK_ON       5'h03
`define LSN_BRK_OFF      5'h04
`define TLK_SEND_CTRL    5'h00
`define TLK_CLR_RX       5'h01
`define TLK_SEND_CHAR    5'h02

`define CTRL_READ_HI     4'h3
`define CTRL_RST_VAL     4'h0
`define CHAR_RST_VAL     8'h00

`define FIFO_DEPTH       16
`define FIFO_AW          4
`define DATA_W           8

`endif

// File: core/byte_fifo.v
// Byte FIFO with valid/ready handshakes on both sides
`timescale 1ns/100ps
module byte_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
)
(
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wp_r;
    reg  [AW-1:0]    rp_r;
    reg  [AW:0]      cnt_r;
    wire             wr_en;
    wire             rd_en;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rp_r];
    assign wr_en     = in_valid & in_ready;
    assign rd_en     = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (wr_en && !flush)
            mem[wp_r] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else if (flush)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (wr_en)
                wp_r <= wp_r + 1'b1;
            if (rd_en)
                rp_r <= rp_r + 1'b1;
            if (wr_en && !rd_en)
                cnt_r <= cnt_r + 1'b1;
            else if (rd_en && !wr_en)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

// File: core/loop_command_mode_control.v
// Command interpreter, register store, readout and local/remote mode of the converter
`timescale 1ns/100ps
`include "loop_cmd_regs.vh"
module loop_command_mode_control
(
    input  wire       CORE_CLK,
    input  wire       NRST,
    input  wire       RESET_KEY,
    input  wire       LSN_CMD_VALID,
    input  wire       TLK_CMD_VALID,
    input  wire [4:0] CMD_CODE,
    input  wire       LISTEN_ADDR_HIT,
    input  wire       TALK_ADDR_HIT,
    input  wire       UNADDRESS,
    input  wire       REMOTE_ENABLE,
    input  wire       NOT_REMOTE_ENABLE,
    input  wire       GO_TO_LOCAL,
    input  wire       NOT_READY_DATA,
    input  wire       SEND_DATA,
    input  wire [7:0] RX_DATA,
    input  wire       RX_VALID,
    output wire       RX_READY,
    output reg  [7:0] TX_DATA,
    output reg        TX_VALID,
    input  wire       TX_ACK,
    output reg        EOT_PULSE,
    output wire [7:0] SER_DATA,
    output wire       SER_VALID,
    input  wire       SER_READY,
    output wire       TX_FLUSH,
    output wire       RX_FLUSH,
    output wire       SER_TXD_BREAK,
    output reg  [7:0] INSTR_DATA,
    output reg        INSTR_VALID,
    output wire       REMOTE_MODE,
    output wire       REMOTE_ARMED,
    output wire       IS_LISTENER,
    output wire       IS_TALKER
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam UPD_IDLE = 2'b00;
    localparam UPD_CTRL = 2'b01;
    localparam UPD_CHAR = 2'b10;

    localparam SRC_NONE = 2'b00;
    localparam SRC_CTRL = 2'b01;
    localparam SRC_CHAR = 2'b10;

    reg  [3:0]  ctrl_reg [0:13];
    reg  [7:0]  char_reg [0:11];
    reg  [1:0]  upd_r;
    reg  [3:0]  upd_idx_r;
    reg  [1:0]  src_r;
    reg         send_act_r;
    reg  [3:0]  send_idx_r;
    reg         brk_r;
    reg         remote_r;
    reg         armed_r;
    reg         lsn_r;
    reg         tlk_r;
    reg         key_s1_r;
    reg         key_s2_r;
    reg         key_prev_r;
    wire        key_press;
    wire        lsn_cmd;
    wire        tlk_cmd;
    wire        byte_take;
    wire        fwd_take;
    wire        upd_take;
    wire [3:0]  grp_last;
    wire [7:0]  read_val;
    wire        fifo_in_ready;
    wire        fifo_in_valid;
    integer     i;

    assign lsn_cmd = LSN_CMD_VALID & lsn_r;
    assign tlk_cmd = TLK_CMD_VALID & tlk_r;

    // ------------------------------------------------------------
    // Reset key synchroniser and press detect
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            key_s1_r   <= 1'b0;
            key_s2_r   <= 1'b0;
            key_prev_r <= 1'b0;
        end
        else
        begin
            key_s1_r   <= RESET_KEY;
            key_s2_r   <= key_s1_r;
            key_prev_r <= key_s2_r;
        end
    end

    assign key_press = key_s2_r & ~key_prev_r;

    // ------------------------------------------------------------
    // Role and local/remote mode
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            lsn_r    <= 1'b0;
            tlk_r    <= 1'b0;
            remote_r <= 1'b0;
            armed_r  <= 1'b0;
        end
        else if (key_press)
        begin
            lsn_r    <= 1'b0;
            tlk_r    <= 1'b0;
            remote_r <= 1'b0;
            armed_r  <= 1'b0;
        end
        else
        begin
            if (LISTEN_ADDR_HIT)
            begin
                lsn_r <= 1'b1;
                tlk_r <= 1'b0;
            end
            else if (TALK_ADDR_HIT)
            begin
                tlk_r <= 1'b1;
                lsn_r <= 1'b0;
            end
            else if (UNADDRESS)
            begin
                lsn_r <= 1'b0;
                tlk_r <= 1'b0;
            end
            if (NOT_REMOTE_ENABLE)
            begin
                armed_r  <= 1'b0;
                remote_r <= 1'b0;
            end
            else if (REMOTE_ENABLE)
                armed_r <= 1'b1;
            else if (GO_TO_LOCAL && lsn_r)
                remote_r <= 1'b0;
            else if (LISTEN_ADDR_HIT && armed_r)
                remote_r <= 1'b1;
            // Role changes alone leave remote_r untouched, except a listen address while armed_r, which sets it
        end
    end

    assign REMOTE_MODE  = remote_r;
    assign REMOTE_ARMED = armed_r;
    assign IS_LISTENER  = lsn_r;
    assign IS_TALKER    = tlk_r;

    // ------------------------------------------------------------
    // Break control and buffer flushes
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            brk_r <= 1'b0;
        else if (key_press)
            brk_r <= 1'b0;
        else if (lsn_cmd && CMD_CODE == `LSN_BRK_ON)
            brk_r <= 1'b1;
        else if (lsn_cmd && CMD_CODE == `LSN_BRK_OFF)
            brk_r <= 1'b0;
    end

    assign SER_TXD_BREAK = brk_r;
    assign TX_FLUSH = lsn_cmd & ((CMD_CODE == `LSN_CLR_TX) | (CMD_CODE == `LSN_BRK_ON)
                      | (CMD_CODE == `LSN_BRK_OFF));
    assign RX_FLUSH = tlk_cmd & (CMD_CODE == `TLK_CLR_RX);

    // ------------------------------------------------------------
    // Incoming data routing
    // ------------------------------------------------------------
    // Register update takes priority, then remote instructions, then forwarding
    assign upd_take      = RX_VALID & (upd_r != UPD_IDLE);
    assign fwd_take      = RX_VALID & (upd_r == UPD_IDLE) & ~remote_r;
    assign fifo_in_valid = fwd_take & ~brk_r;
    assign RX_READY      = (upd_r != UPD_IDLE) | remote_r | (fifo_in_ready & ~brk_r);
    assign byte_take     = RX_VALID & RX_READY;
    assign grp_last      = (upd_r == UPD_CTRL) ? `CTRL_LAST_IDX : `CHAR_LAST_IDX;

    byte_fifo
    #(
        .WIDTH (`DATA_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    )
    u_tx_fifo
    (
        .clk       (CORE_CLK),
        .rst_n     (NRST),
        .flush     (TX_FLUSH),
        .in_data   (RX_DATA),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (SER_DATA),
        .out_valid (SER_VALID),
        .out_ready (SER_READY & ~brk_r)
    );

    // ------------------------------------------------------------
    // Register update sequencer and register store
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            upd_r     <= UPD_IDLE;
            upd_idx_r <= 4'h0;
        end
        else if (key_press || LISTEN_ADDR_HIT)
        begin
            upd_r     <= UPD_IDLE;
            upd_idx_r <= 4'h0;
        end
        else if (lsn_cmd && CMD_CODE == `LSN_SET_CTRL)
        begin
            upd_r     <= UPD_CTRL;
            upd_idx_r <= 4'h0;
        end
        else if (lsn_cmd && CMD_CODE == `LSN_SET_CHAR)
        begin
            upd_r     <= UPD_CHAR;
            upd_idx_r <= 4'h0;
        end
        else if (upd_take)
        begin
            if (upd_idx_r == grp_last)
            begin
                upd_r     <= UPD_IDLE;
                upd_idx_r <= 4'h0;
            end
            else
                upd_idx_r <= upd_idx_r + 4'h1;
        end
    end

    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            for (i = 0; i < 14; i = i + 1)
                ctrl_reg[i] <= `CTRL_RST_VAL;
            for (i = 0; i < 12; i = i + 1)
                char_reg[i] <= `CHAR_RST_VAL;
        end
        else if (upd_take && !LISTEN_ADDR_HIT && !lsn_cmd && !key_press)
        begin
            if (upd_r == UPD_CTRL)
                ctrl_reg[upd_idx_r] <= RX_DATA[3:0];
            else
                char_reg[upd_idx_r] <= RX_DATA;
        end
    end

    // ------------------------------------------------------------
    // Remote instruction output
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            INSTR_DATA  <= 8'h00;
            INSTR_VALID <= 1'b0;
        end
        else
        begin
            INSTR_VALID <= byte_take & (upd_r == UPD_IDLE) & remote_r;
            if (byte_take && upd_r == UPD_IDLE && remote_r)
                INSTR_DATA <= RX_DATA;
        end
    end

    // ------------------------------------------------------------
    // Register readout
    // ------------------------------------------------------------
    assign read_val = (src_r == SRC_CTRL) ? {`CTRL_READ_HI, ctrl_reg[send_idx_r]}
                                          : char_reg[send_idx_r];

    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            src_r      <= SRC_NONE;
            send_act_r <= 1'b0;
            send_idx_r <= 4'h0;
            TX_DATA    <= 8'h00;
            TX_VALID   <= 1'b0;
            EOT_PULSE  <= 1'b0;
        end
        else if (key_press)
        begin
            src_r      <= SRC_NONE;
            send_act_r <= 1'b0;
            send_idx_r <= 4'h0;
            TX_VALID   <= 1'b0;
            EOT_PULSE  <= 1'b0;
        end
        else
        begin
            EOT_PULSE <= 1'b0;
            if (tlk_cmd && CMD_CODE == `TLK_SEND_CTRL)
            begin
                src_r      <= SRC_CTRL;
                send_act_r <= 1'b0;
                send_idx_r <= 4'h0;
                TX_VALID   <= 1'b0;
            end
            else if (tlk_cmd && CMD_CODE == `TLK_SEND_CHAR)
            begin
                src_r      <= SRC_CHAR;
                send_act_r <= 1'b0;
                send_idx_r <= 4'h0;
                TX_VALID   <= 1'b0;
            end
            else if (send_act_r && NOT_READY_DATA)
            begin
                send_act_r <= 1'b0;
                src_r      <= SRC_NONE;
                TX_VALID   <= 1'b0;
                EOT_PULSE  <= 1'b1;
            end
            else if (!send_act_r && SEND_DATA && tlk_r && src_r != SRC_NONE)
            begin
                send_act_r <= 1'b1;
                send_idx_r <= 4'h0;
                TX_DATA    <= read_val;
                TX_VALID   <= 1'b1;
            end
            else if (send_act_r && TX_VALID && TX_ACK)
            begin
                if (send_idx_r == ((src_r == SRC_CTRL) ? `CTRL_LAST_IDX : `CHAR_LAST_IDX))
                begin
                    send_act_r <= 1'b0;
                    src_r      <= SRC_NONE;
                    TX_VALID   <= 1'b0;
                    EOT_PULSE  <= 1'b1;
                end
                else
                begin
                    send_idx_r <= send_idx_r + 4'h1;
                    TX_DATA    <= (src_r == SRC_CTRL)
                                  ? {`CTRL_READ_HI, ctrl_reg[send_idx_r + 4'h1]}
                                  : char_reg[send_idx_r + 4'h1];
                end
            end
        end
    end
endmodule

// File: test/loop_ctrl_model.sv
// Loop controller model: command pulses, data bytes and readout acknowledge
`timescale 1ns/100ps
module loop_ctrl_model
(
    input  logic       clk,
    output logic [9:0] m = '0,
    output logic [4:0] code = '0,
    output logic [7:0] rxd = '0,
    output logic       rxv = 1'b0,
    input  logic       rx_rdy,
    input  logic [7:0] tx_d,
    input  logic       tx_v,
    output logic       tx_ack = 1'b0
);
    logic       slow = 1'b0;
    logic       tgl = 1'b0;
    logic [7:0] got[$];
    // One-cycle message; the code lines are scrambled once released
    task msg(input int b, input logic [4:0] c);
        @(posedge clk);
        m <= 10'h001 << b;
        code <= c;
        @(posedge clk);
        m <= '0;
        code <= ~c;
    endtask
    // Data byte held until the edge at which ready is high
    task put(input logic [7:0] d);
        int n;
        @(posedge clk);
        rxd <= d;
        rxv <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (!rx_rdy && n < 100);
        @(posedge clk);
        rxv <= 1'b0;
        rxd <= ~d;
    endtask
    // Slow mode acknowledges only every other opportunity
    always @(posedge clk)
    begin
        if (tx_v && !tx_ack)
            tgl <= ~tgl;
        tx_ack <= tx_v && !tx_ack && (!slow || tgl);
        if (tx_v && tx_ack)
            got.push_back(tx_d);
    end
endmodule

// File: test/loop_command_mode_control_sva.sv
// Assertions on the command-mode control block ports
`timescale 1ns/100ps
module loop_cmd_sva
(
    input logic       CORE_CLK,
    input logic       NRST,
    input logic       RESET_KEY,
    input logic       LSN_CMD_VALID,
    input logic       TLK_CMD_VALID,
    input logic [4:0] CMD_CODE,
    input logic       LISTEN_ADDR_HIT,
    input logic       REMOTE_ENABLE,
    input logic       NOT_REMOTE_ENABLE,
    input logic       GO_TO_LOCAL,
    input logic       NOT_READY_DATA,
    input logic       TX_VALID,
    input logic       EOT_PULSE,
    input logic       TX_FLUSH,
    input logic       RX_FLUSH,
    input logic       SER_TXD_BREAK,
    input logic       REMOTE_MODE,
    input logic       REMOTE_ARMED,
    input logic       IS_LISTENER,
    input logic       IS_TALKER
);
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    wire lc = LSN_CMD_VALID && IS_LISTENER;
    a_break_on: assert property (lc && CMD_CODE == 5'h03
        |-> TX_FLUSH ##1 SER_TXD_BREAK) else $error("break not started");
    a_break_off: assert property (lc && CMD_CODE == 5'h04
        |-> TX_FLUSH ##1 !SER_TXD_BREAK) else $error("break not ended");
    a_clear_tx: assert property (lc && CMD_CODE == 5'h01
        |-> TX_FLUSH) else $error("transmit buffer not cleared");
    a_clear_rx: assert property (TLK_CMD_VALID && CMD_CODE == 5'h01
        |-> RX_FLUSH == IS_TALKER) else $error("receive buffer clear wrong");
    a_nre_local: assert property (NOT_REMOTE_ENABLE
        |=> !REMOTE_MODE && !REMOTE_ARMED) else $error("not local after disable");
    a_ren_arms: assert property (REMOTE_ENABLE && !NOT_REMOTE_ENABLE && !RESET_KEY
        && !REMOTE_MODE && !LISTEN_ADDR_HIT |=> REMOTE_ARMED && !REMOTE_MODE)
        else $error("remote enable handled wrong");
    a_listen_remote: assert property (LISTEN_ADDR_HIT && REMOTE_ARMED && !RESET_KEY
        && !NOT_REMOTE_ENABLE && !GO_TO_LOCAL |=> REMOTE_MODE && IS_LISTENER)
        else $error("not remote after listen");
    a_gtl_local: assert property (GO_TO_LOCAL && IS_LISTENER && !RESET_KEY
        && !NOT_REMOTE_ENABLE && !REMOTE_ENABLE |=> !REMOTE_MODE && $stable(REMOTE_ARMED))
        else $error("go to local handled wrong");
    a_remote_keep: assert property (REMOTE_MODE && !RESET_KEY && !NOT_REMOTE_ENABLE
        && !(GO_TO_LOCAL && IS_LISTENER) |=> REMOTE_MODE) else $error("remote mode lost");
    a_eot_stop: assert property (NOT_READY_DATA && TX_VALID
        |=> EOT_PULSE ##1 !TX_VALID && !EOT_PULSE) else $error("readout not ended");
endmodule
bind loop_command_mode_control loop_cmd_sva u_sva (.*);

// File: test/test_loop_command_mode_control.sv
// Self-checking bench for the loop command-mode control block
`timescale 1ns/100ps
module test_loop_command_mode_control;
    localparam int L = 0, T = 1, LH = 2, TH = 3, UN = 4, RE = 5, NR = 6, GT = 7, NF = 8, SD = 9;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       key = 1'b0;
    logic       ser_rdy = 1'b1;
    logic [9:0] m;
    logic [4:0] code;
    logic [7:0] rxd;
    logic       rxv;
    wire  [7:0] tx_d, ser_d, ins_d;
    wire        rx_rdy, tx_v, tx_ack, eot, ser_v, txf, rxf, brk, ins_v, rem, arm;
    int         err_total = 0;
    int         samples_checked = 0;
    int         eot_n = 0, txf_n = 0, rxf_n = 0, a, b;
    logic [7:0] ser_q[$], ins_q[$], exp_q[$];
    // Listener flag, code, expected transmit flush, receive flush, break
    logic [8:0] rows[8] = '{9'h10c, 9'h11d, 9'h124, 9'h128, 9'h1f8, 9'h00a, 9'h018, 9'h0f8};

    initial forever #25 clk = ~clk;

    loop_ctrl_model p (.clk(clk), .m(m), .code(code), .rxd(rxd), .rxv(rxv),
        .rx_rdy(rx_rdy), .tx_d(tx_d), .tx_v(tx_v), .tx_ack(tx_ack));

    loop_command_mode_control DUT (.CORE_CLK(clk), .NRST(nrst), .RESET_KEY(key),
        .LSN_CMD_VALID(m[L]), .TLK_CMD_VALID(m[T]), .CMD_CODE(code),
        .LISTEN_ADDR_HIT(m[LH]), .TALK_ADDR_HIT(m[TH]), .UNADDRESS(m[UN]),
        .REMOTE_ENABLE(m[RE]), .NOT_REMOTE_ENABLE(m[NR]), .GO_TO_LOCAL(m[GT]),
        .NOT_READY_DATA(m[NF]), .SEND_DATA(m[SD]), .RX_DATA(rxd), .RX_VALID(rxv),
        .RX_READY(rx_rdy), .TX_DATA(tx_d), .TX_VALID(tx_v), .TX_ACK(tx_ack),
        .EOT_PULSE(eot), .SER_DATA(ser_d), .SER_VALID(ser_v), .SER_READY(ser_rdy),
        .TX_FLUSH(txf), .RX_FLUSH(rxf), .SER_TXD_BREAK(brk), .INSTR_DATA(ins_d),
        .INSTR_VALID(ins_v), .REMOTE_MODE(rem), .REMOTE_ARMED(arm),
        .IS_LISTENER(), .IS_TALKER());

    always @(posedge clk)
    begin
        eot_n <= eot_n + int'(eot);
        txf_n <= txf_n + int'(txf);
        rxf_n <= rxf_n + int'(rxf);
        if (ser_v && ser_rdy)
            ser_q.push_back(ser_d);
        if (ins_v)
            ins_q.push_back(ins_d);
    end

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task mode(input logic r, input logic f);
        @(negedge clk);
        chk("remote", {7'h00, r}, {7'h00, rem});
        chk("armed", {7'h00, f}, {7'h00, arm});
    endtask

    // One data byte; f says whether it must reach the serial side
    task send(input logic [7:0] d, input logic f);
        ser_q.delete();
        p.put(d);
        repeat (4) @(posedge clk);
        chk("fwd count", {7'h00, f}, 8'(ser_q.size()));
        if (f)
            chk("fwd byte", d, ser_q[0]);
    endtask

    task readout(input logic [4:0] c);
        p.msg(TH, 5'h00);
        p.msg(T, c);
        p.got.delete();
        a = eot_n;
        p.msg(SD, 5'h00);
        for (int i = 0; i < 300 && eot_n == a; i++)
            @(posedge clk);
        chk("read count", 8'(exp_q.size()), 8'(p.got.size()));
        foreach (exp_q[i])
            chk("read byte", exp_q[i], p.got[i]);
    endtask

    task complete_run();
        $display("Checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        mode(1'b0, 1'b0);
        foreach (rows[i])
        begin
            p.msg(rows[i][8] ? LH : TH, 5'h00);
            a = txf_n;
            b = rxf_n;
            p.msg(rows[i][8] ? L : T, rows[i][7:3]);
            @(negedge clk);
            chk("tx flush", {7'h00, rows[i][2]}, 8'(txf_n - a));
            chk("rx flush", {7'h00, rows[i][1]}, 8'(rxf_n - b));
            chk("break", {7'h00, rows[i][0]}, {7'h00, brk});
        end
        p.msg(LH, 5'h00);
        ser_rdy <= 1'b0;
        for (int i = 0; i < 16; i++)
            p.put(8'h80 + 8'(i));
        @(negedge clk);
        chk("ready when full", 8'h00, {7'h00, rx_rdy});
        ser_q.delete();
        @(posedge clk);
        ser_rdy <= 1'b1;
        repeat (24) @(posedge clk);
        chk("drained", 8'h10, 8'(ser_q.size()));
        foreach (ser_q[i])
            chk("drained byte", 8'h80 + 8'(i), ser_q[i]);
        p.slow = 1'b1;
        p.msg(L, 5'h00);
        for (int i = 0; i < 14; i++)
            p.put(8'hc0 + 8'(13 - i));
        send(8'hbf, 1'b1);
        exp_q.delete();
        for (int i = 0; i < 14; i++)
            exp_q.push_back(8'h30 + 8'(13 - i));
        readout(5'h00);
        p.slow = 1'b0;
        p.msg(LH, 5'h00);
        p.msg(L, 5'h02);
        exp_q.delete();
        for (int i = 0; i < 12; i++)
        begin
            p.put(8'h41 + 8'(i));
            exp_q.push_back(8'h41 + 8'(i));
        end
        readout(5'h02);
        p.msg(LH, 5'h00);
        p.msg(L, 5'h02);
        for (int i = 0; i < 3; i++)
            p.put(8'h61 + 8'(i));
        p.msg(LH, 5'h00);
        send(8'h5a, 1'b1);
        p.msg(TH, 5'h00);
        p.msg(T, 5'h02);
        p.got.delete();
        a = eot_n;
        p.msg(SD, 5'h00);
        for (int i = 0; i < 100 && p.got.size() < 3; i++)
            @(posedge clk);
        p.msg(NF, 5'h00);
        repeat (4) @(posedge clk);
        chk("eot count", 8'h01, 8'(eot_n - a));
        chk("partial byte", 8'h63, p.got[2]);
        b = p.got.size();
        p.msg(SD, 5'h00);
        repeat (6) @(posedge clk);
        chk("after eot", 8'(b), 8'(p.got.size()));
        p.msg(LH, 5'h00);
        p.msg(RE, 5'h00);
        mode(1'b0, 1'b1);
        send(8'h33, 1'b1);
        p.msg(LH, 5'h00);
        mode(1'b1, 1'b1);
        send(8'h52, 1'b0);
        chk("instruction", 8'h52, ins_q[0]);
        p.msg(TH, 5'h00);
        mode(1'b1, 1'b1);
        p.msg(UN, 5'h00);
        p.msg(GT, 5'h00);
        mode(1'b1, 1'b1);
        p.msg(LH, 5'h00);
        p.msg(GT, 5'h00);
        mode(1'b0, 1'b1);
        p.msg(LH, 5'h00);
        mode(1'b1, 1'b1);
        p.msg(TH, 5'h00);
        p.msg(NR, 5'h00);
        mode(1'b0, 1'b0);
        p.msg(LH, 5'h00);
        mode(1'b0, 1'b0);
        p.msg(RE, 5'h00);
        p.msg(LH, 5'h00);
        mode(1'b1, 1'b1);
        @(posedge clk);
        key <= 1'b1;
        repeat (10) @(posedge clk);
        key <= 1'b0;
        @(negedge clk);
        chk("key local", 8'h00, {7'h00, rem});
        complete_run();
    end
endmodule
